// >>> core/sttr_check_enc.sv
/*
 Classifies the storage errors of one storage cycle into a check code,
 a protection flag and a program check flag.
 Assumes the error indications are valid in the grant cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module sttr_check_enc (
    input wire sttr_pkg::sttr_op_t op_in,
    input wire logic read_protect_in,
    input wire sttr_pkg::sttr_mem_err_t err_in,
    output logic [2:0] code_out,
    output logic prot_out,
    output logic prog_out
);
    import sttr_pkg::*;

    logic any_err;

    // Code per operation; CC_UNUSED is never produced
    always_comb begin
        any_err = |err_in;
        code_out = CC_NONE;
        prot_out = 1'b0;
        prog_out = 1'b0;
        case (op_in)
            OP_RD_HARD: begin
                if (any_err) code_out = CC_RD_HARD;
            end
            OP_WR_HARD: begin
                if (any_err) code_out = CC_WR_HARD;
            end
            OP_WR_TABLED: begin
                if (err_in.addr_check) code_out = CC_WR_TABLED;
                prot_out = err_in.protection;
                prog_out = err_in.addressing;
            end
            OP_RD_CHAIN: begin
                if (err_in.addr_check || err_in.parity) begin
                    code_out = CC_RD_CHAIN;
                end
                prot_out = err_in.protection & read_protect_in;
                prog_out = err_in.addressing;
            end
            OP_WR_NCA: begin
                if (any_err) code_out = CC_WR_NCA;
            end
            OP_RD_NCA: begin
                if (any_err) code_out = CC_RD_NCA;
            end
            default: begin
                code_out = CC_NONE;
            end
        endcase
    end
endmodule : sttr_check_enc
`default_nettype wire

// >>> core/sttr_pkg.sv
/*
 Shared constants and types for the status table error reporter.
 Assumes one 100 MHz clock with a synchronous active-low reset.
*/
// Operation
// - Storage protection on tabled write, or protected chain read, sets protection bit.
// - Bit 12 of the report word is always written as zero.
// - Hardware checks report a three-bit code in bits 13-15; 000 means none.
// - Code 001 for hard control word read error, 010 for its write.
// - Code 011 for tabled write address check, 111 for chain read checks.
// - Code 101 for address word write, 110 for its read; never 100.
// - Several checks are not merged; the earliest code is kept and written.
// - Bits 16-31 carry the remaining byte count when the report is written.
// - Error reports may overwrite interrupt-flag reports; afterwards the block halts.
// - Report written without awaiting priority; servicing continues while request pending.
// - A tabled word stored without error raises the interrupt request.
// - The interrupt request drops when the priority grant arrives.
// - In idle mode no control word is touched and no request raised.
// - A status table interrupt is taken only while the mask bit is one.
// - Storage is requested, granted to one channel, held one storage cycle.
// - Report bit 8 is set when a chain read carries the interrupt flag.
// - On error the hard word goes to error-terminate, held until replaced.
package sttr_pkg;
    // Mode field of the hard control word
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ERR_TERM = 3'h1;
    localparam logic [2:0] MODE_ACTIVE = 3'h4;

    // Check codes
    localparam logic [2:0] CC_NONE = 3'h0;
    localparam logic [2:0] CC_RD_HARD = 3'h1;
    localparam logic [2:0] CC_WR_HARD = 3'h2;
    localparam logic [2:0] CC_WR_TABLED = 3'h3;
    localparam logic [2:0] CC_UNUSED = 3'h4;
    localparam logic [2:0] CC_WR_NCA = 3'h5;
    localparam logic [2:0] CC_RD_NCA = 3'h6;
    localparam logic [2:0] CC_RD_CHAIN = 3'h7;

    // Report word fields, bit 0 being the most significant
    localparam int RW_W = 32;
    localparam int RW_PCI = 31 - 8;
    localparam int RW_TEX = 31 - 9;
    localparam int RW_PROG = 31 - 10;
    localparam int RW_PROT = 31 - 11;
    localparam int RW_ZERO = 31 - 12;
    localparam int RW_CC_HI = 31 - 13;
    localparam int RW_CC_LO = 31 - 15;
    localparam int RW_CNT_HI = 31 - 16;
    localparam int CNT_W = 16;

    // Storage operations issued by the subchannel
    typedef enum logic [2:0] {
        OP_RD_HARD = 3'h0,
        OP_WR_HARD = 3'h1,
        OP_WR_TABLED = 3'h2,
        OP_RD_CHAIN = 3'h3,
        OP_WR_NCA = 3'h4,
        OP_RD_NCA = 3'h5,
        OP_WR_REPORT = 3'h6
    } sttr_op_t;

    // Storage error indications returned with a grant
    typedef struct packed {
        logic addressing;
        logic protection;
        logic addr_check;
        logic parity;
    } sttr_mem_err_t;

    // Storage request as driven to the processor
    typedef struct packed {
        logic req;
        sttr_op_t op;
    } sttr_mem_req_t;

    // Operation handed in by the subchannel sequencer
    typedef struct packed {
        logic valid;
        sttr_op_t op;
        logic read_protect;
        logic pci_flag;
        logic table_exhausted;
        logic format_error;
    } sttr_cmd_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STORE = 2'b01,
        ST_REPORT = 2'b10,
        ST_HALT = 2'b11
    } sttr_state_t;
endpackage : sttr_pkg

// >>> core/sttr_subchannel.sv
/*
 Status table error reporter: runs the subchannel's storage cycles,
 builds the report word, halts on error and raises the interrupt request.
 Assumes the processor grants storage one cycle at a time and returns
 errors with the grant, and that software owns the control words.
*/
`timescale 1ns/10ps
`default_nettype none
module sttr_subchannel (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire sttr_pkg::sttr_cmd_t cmd_in,
    input wire logic [2:0] mode_in,
    input wire logic [15:0] count_in,
    input wire logic mem_grant_in,
    input wire sttr_pkg::sttr_mem_err_t mem_err_in,
    input wire logic prio_grant_in,
    input wire logic mask_bit_in,
    output logic cmd_ready_out,
    output sttr_pkg::sttr_mem_req_t mem_out,
    output logic [31:0] mem_wdata_out,
    output logic int_req_out,
    output logic set_err_term_out,
    output logic halted_out
);
    import sttr_pkg::*;

    sttr_state_t state_reg, state_next;
    sttr_cmd_t cmd_reg, cmd_next;
    sttr_mem_req_t mem_reg, mem_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [2:0] first_code_reg, first_code_next;
    logic err_rpt_reg, err_rpt_next;
    logic int_reg, int_next;
    logic set_term_reg, set_term_next;
    logic ready_reg, ready_next;
    logic halt_reg, halt_next;
    logic [2:0] enc_code;
    logic enc_prot;
    logic enc_prog;
    logic [2:0] code_now;
    logic is_err;
    logic int_set;
    logic int_take;

    // Error classification of the current storage cycle
    sttr_check_enc u_enc (
        .op_in(cmd_reg.op),
        .read_protect_in(cmd_reg.read_protect),
        .err_in(mem_err_in),
        .code_out(enc_code),
        .prot_out(enc_prot),
        .prog_out(enc_prog)
    );

    // Sequencer and report word assembly
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        mem_next = mem_reg;
        wdata_next = wdata_reg;
        first_code_next = first_code_reg;
        err_rpt_next = err_rpt_reg;
        set_term_next = 1'b0;
        int_set = 1'b0;
        code_now = (first_code_reg != CC_NONE) ? first_code_reg : enc_code;
        is_err = (enc_code != CC_NONE) | enc_prot | enc_prog
            | cmd_reg.format_error | cmd_reg.table_exhausted;
        case (state_reg)
            ST_IDLE: begin
                // Nothing is started while the mode is idle
                if (cmd_in.valid && mode_in != MODE_IDLE) begin
                    cmd_next = cmd_in;
                    mem_next.req = 1'b1;
                    mem_next.op = cmd_in.op;
                    state_next = ST_STORE;
                end
            end
            ST_STORE: begin
                if (mem_grant_in) begin
                    mem_next.req = 1'b0;
                    first_code_next = code_now;
                    if (is_err || cmd_reg.pci_flag) begin
                        wdata_next = '0;
                        wdata_next[RW_PCI] = cmd_reg.pci_flag;
                        wdata_next[RW_TEX] = cmd_reg.table_exhausted;
                        wdata_next[RW_PROG] = enc_prog | cmd_reg.format_error;
                        wdata_next[RW_PROT] = enc_prot;
                        wdata_next[RW_CC_HI:RW_CC_LO] = code_now;
                        wdata_next[RW_CNT_HI:0] = count_in;
                        err_rpt_next = is_err;
                        // Written at once, no wait for priority
                        mem_next.req = 1'b1;
                        mem_next.op = OP_WR_REPORT;
                        state_next = ST_REPORT;
                    end else begin
                        int_set = (cmd_reg.op == OP_WR_TABLED);
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_REPORT: begin
                if (mem_grant_in) begin
                    mem_next.req = 1'b0;
                    int_set = 1'b1;
                    if (err_rpt_reg) begin
                        set_term_next = 1'b1;
                        state_next = ST_HALT;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_HALT: begin
                // Left only once software has replaced the hard word
                if (mode_in == MODE_IDLE) begin
                    first_code_next = CC_NONE;
                    err_rpt_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Status outputs follow the state being entered
        ready_next = (state_next == ST_IDLE);
        halt_next = (state_next == ST_HALT);
    end

    // Interrupt request: held until a masked-in priority grant; set wins
    always_comb begin
        int_take = prio_grant_in & mask_bit_in;
        int_next = int_reg;
        if (int_take) begin
            int_next = 1'b0;
        end
        if (int_set && mode_in != MODE_IDLE) begin
            int_next = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state_reg <= ST_IDLE;
            cmd_reg <= '0;
            mem_reg <= '0;
            wdata_reg <= '0;
            first_code_reg <= CC_NONE;
            err_rpt_reg <= 1'b0;
            int_reg <= 1'b0;
            set_term_reg <= 1'b0;
            ready_reg <= 1'b1;
            halt_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            mem_reg <= mem_next;
            wdata_reg <= wdata_next;
            first_code_reg <= first_code_next;
            err_rpt_reg <= err_rpt_next;
            int_reg <= int_next;
            set_term_reg <= set_term_next;
            ready_reg <= ready_next;
            halt_reg <= halt_next;
        end
    end

    // Outputs straight from flip-flops
    assign cmd_ready_out = ready_reg;
    assign mem_out = mem_reg;
    assign mem_wdata_out = wdata_reg;
    assign int_req_out = int_reg;
    assign set_err_term_out = set_term_reg;
    assign halted_out = halt_reg;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_report_grant;
        state_reg == ST_REPORT && mem_grant_in;
    endsequence
    sequence s_clean_tabled;
        state_reg == ST_STORE && mem_grant_in && !is_err
            && !cmd_reg.pci_flag && cmd_reg.op == OP_WR_TABLED
            && mode_in != MODE_IDLE;
    endsequence

    AST_BIT12_ZERO: assert property (
        mem_out.op == OP_WR_REPORT |-> !mem_wdata_out[RW_ZERO])
        else $error("report bit 12 not zero");
    AST_NO_CODE_100: assert property (
        mem_out.op == OP_WR_REPORT
            |-> mem_wdata_out[RW_CC_HI:RW_CC_LO] != CC_UNUSED)
        else $error("unused check code written");
    AST_FIRST_CODE_KEPT: assert property (
        first_code_reg != CC_NONE && state_reg != ST_HALT
            |=> $stable(first_code_reg))
        else $error("earliest check code lost");
    AST_HALT_AFTER_ERR: assert property (
        s_report_grant ##0 err_rpt_reg
            |=> halted_out && set_err_term_out ##1 !set_err_term_out)
        else $error("no halt after error report");
    AST_INT_AFTER_TABLED: assert property (
        s_clean_tabled |=> int_req_out)
        else $error("no request after tabled word");
    AST_DROP_ON_PRIO: assert property (
        int_req_out && prio_grant_in && mask_bit_in && !int_set
            |=> !int_req_out)
        else $error("request not dropped on priority");
    AST_MASKED_HOLD: assert property (
        int_req_out && !mask_bit_in |=> int_req_out)
        else $error("request taken while masked");
    AST_IDLE_QUIET: assert property (
        mode_in == MODE_IDLE && !int_req_out |=> !int_req_out)
        else $error("request raised in idle mode");
    AST_REQ_UNTIL_GRANT: assert property (
        int_req_out && !(prio_grant_in && mask_bit_in) |=> int_req_out)
        else $error("request dropped without grant");
    AST_RESIDUE: assert property (
        state_reg == ST_STORE && mem_grant_in && cmd_reg.pci_flag
            |=> mem_wdata_out[RW_CNT_HI:0] == $past(count_in))
        else $error("residue count wrong");
endmodule : sttr_subchannel
`default_nettype wire

// >>> testbench/sttr_proc_model.sv
/*
 Processor and main storage model facing the status table subchannel.
 Assumes the subchannel holds its storage request until granted and
 that the bench chooses which operation, if any, sees storage errors.
*/
`timescale 1ns/10ps
`default_nettype none
module sttr_proc_model (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire sttr_pkg::sttr_mem_req_t mem_in,
    input wire logic int_req_in,
    input wire logic [2:0] delay_in,
    input wire sttr_pkg::sttr_op_t err_op_in,
    input wire sttr_pkg::sttr_mem_err_t err_val_in,
    input wire logic prio_en_in,
    output logic mem_grant_out,
    output sttr_pkg::sttr_mem_err_t mem_err_out,
    output logic prio_grant_out
);
    import sttr_pkg::*;
    logic [2:0] wait_cnt;

    // Storage grant after a chosen delay, interrupt priority when enabled
    always_ff @(posedge clk_sys_in) begin
        mem_grant_out <= 1'b0;
        prio_grant_out <= 1'b0;
        mem_err_out <= ~mem_err_out; // Error lines mean nothing off a grant
        if (!rst_b_in) begin
            wait_cnt <= 3'h0;
            mem_err_out <= 4'h5;
        end else begin
            if (mem_in.req && !mem_grant_out) begin
                if (wait_cnt >= delay_in) begin
                    mem_grant_out <= 1'b1; // One storage cycle each
                    wait_cnt <= 3'h0;
                    // Errors only on the operation the bench picked
                    mem_err_out <= (mem_in.op == err_op_in) ?
                        err_val_in : 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
            if (int_req_in && prio_en_in && !prio_grant_out) begin
                prio_grant_out <= 1'b1;
            end
        end
    end
endmodule : sttr_proc_model
`default_nettype wire

// >>> testbench/sttr_subchannel_tb.sv
/*
 Self-checking bench for the status table subchannel.
 Assumes the processor model answers storage and priority requests.
*/
`timescale 1ns/10ps
`default_nettype none
module sttr_subchannel_tb;
    import sttr_pkg::*;
    logic clk_sys_in, rst_b_in, mask_bit_in, prio_en, cmd_ready_out;
    logic mem_grant_in, prio_grant_in, int_req_out, set_err_term_out;
    logic halted_out;
    logic [2:0] mode_in, delay;
    logic [1:0] flags;
    logic [15:0] count_in;
    logic [31:0] mem_wdata_out, rep_word;
    sttr_cmd_t cmd_in;
    sttr_mem_err_t mem_err_in, err_val;
    sttr_mem_req_t mem_out;
    sttr_op_t err_op;
    int miscompares = 0, cmp_count = 0, rep_cnt = 0, et_cnt = 0, cycles = 0;

    sttr_subchannel dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .cmd_in(cmd_in), .mode_in(mode_in), .count_in(count_in),
        .mem_grant_in(mem_grant_in), .mem_err_in(mem_err_in),
        .prio_grant_in(prio_grant_in), .mask_bit_in(mask_bit_in),
        .cmd_ready_out(cmd_ready_out), .mem_out(mem_out),
        .mem_wdata_out(mem_wdata_out), .int_req_out(int_req_out),
        .set_err_term_out(set_err_term_out), .halted_out(halted_out));
    sttr_proc_model proc (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .mem_in(mem_out), .int_req_in(int_req_out), .delay_in(delay),
        .err_op_in(err_op), .err_val_in(err_val), .prio_en_in(prio_en),
        .mem_grant_out(mem_grant_in), .mem_err_out(mem_err_in),
        .prio_grant_out(prio_grant_in));

    // Clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Report capture, mode write-back and hang guard
    always @(posedge clk_sys_in) begin
        if (mem_grant_in && mem_out.req && mem_out.op == OP_WR_REPORT) begin
            rep_word <= mem_wdata_out;
            rep_cnt <= rep_cnt + 1;
        end
        if (set_err_term_out === 1'b1) begin
            et_cnt <= et_cnt + 1;
            mode_in <= MODE_ERR_TERM;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // Expected report word from code, protection and interrupt flag
    function automatic logic [31:0] rw(input logic [2:0] cc,
            input logic prot, input logic pci);
        rw = 32'h0;
        rw[RW_CC_HI:RW_CC_LO] = cc;
        rw[RW_PROT] = prot;
        rw[RW_PCI] = pci;
        rw[RW_CNT_HI:0] = count_in;
    endfunction : rw

    task automatic reset_dut(input int n, input logic [15:0] cnt);
        @(posedge clk_sys_in) begin
            rst_b_in <= 1'b0;
            mode_in <= MODE_ACTIVE;
            cmd_in <= '0;
            prio_en <= 1'b1;
            mask_bit_in <= 1'b1;
            count_in <= cnt;
        end
        repeat (n) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(negedge clk_sys_in);
        check({cmd_ready_out, mem_out.req, int_req_out, halted_out},
            32'h8, "reset outputs");
    endtask : reset_dut

    task automatic run_op(input sttr_op_t op, input logic pci,
            input sttr_mem_err_t err, input logic exp_rep,
            input logic [31:0] exp_word, input logic exp_halt);
        int r0, e0, n;
        r0 = rep_cnt;
        e0 = et_cnt;
        n = 0;
        @(posedge clk_sys_in) begin
            err_op <= op;
            err_val <= err;
            cmd_in <= {1'b1, op, 1'b1, pci, flags};
        end
        @(posedge clk_sys_in) cmd_in.valid <= 1'b0;
        @(negedge clk_sys_in);
        while (n < 60 && (exp_rep ? rep_cnt == r0 : cmd_ready_out !== 1'b1))
        begin
            @(negedge clk_sys_in);
            n++;
        end
        repeat (3) @(negedge clk_sys_in);
        check(rep_cnt - r0, {31'h0, exp_rep}, "report written");
        if (exp_rep) check(rep_word, exp_word, "report word");
        check(halted_out, exp_halt, "halted");
        check(et_cnt - e0, {31'h0, exp_halt}, "error terminate");
    endtask : run_op

    // Every check code, plus protection on write and protected read
    task automatic test_codes();
        sttr_op_t ops[9] = '{OP_RD_HARD, OP_WR_HARD, OP_WR_TABLED, OP_WR_NCA,
            OP_RD_NCA, OP_RD_CHAIN, OP_RD_CHAIN, OP_WR_TABLED, OP_RD_CHAIN};
        logic [3:0] errs[9] = '{4'h1, 4'h8, 4'h2, 4'h1, 4'h2, 4'h1, 4'h2,
            4'h4, 4'h4};
        logic [2:0] cc[9] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h7,
            3'h0, 3'h0};
        for (int i = 0; i < 9; i++) begin
            reset_dut(2, 16'h0a08 + 16'(i * 8));
            delay <= 3'(i % 4);
            run_op(ops[i], 1'b0, errs[i], 1'b1,
                rw(cc[i], i > 6, 1'b0), 1'b1);
        end
    endtask : test_codes

    // Exhausted table, format error and addressing all report and halt
    task automatic test_flags();
        logic [31:0] exp;
        sttr_mem_err_t err;
        for (int i = 0; i < 3; i++) begin
            reset_dut(2, 16'h0018);
            exp = rw(CC_NONE, 1'b0, 1'b0);
            exp[(i == 0) ? RW_TEX : RW_PROG] = 1'b1;
            err = (i == 2) ? 4'h8 : 4'h0;
            flags <= (i == 0) ? 2'b10 : ((i == 1) ? 2'b01 : 2'b00);
            run_op(OP_WR_TABLED, 1'b0, err, 1'b1, exp, 1'b1);
        end
        flags <= 2'b00;
    endtask : test_flags

    // Interrupt flag report, then an error report overlays it
    task automatic test_pci_overlay();
        reset_dut(2, 16'h0110);
        run_op(OP_RD_CHAIN, 1'b1, 4'h0, 1'b1, rw(3'h0, 1'b0, 1'b1), 1'b0);
        run_op(OP_WR_HARD, 1'b0, 4'h1, 1'b1, rw(3'h2, 1'b0, 1'b0), 1'b1);
        repeat (5) @(negedge clk_sys_in);
        check(halted_out, 1'b1, "halt held");
        // Software replacing the hard word releases the halt
        @(posedge clk_sys_in) mode_in <= MODE_IDLE;
        repeat (2) @(negedge clk_sys_in);
        check({halted_out, cmd_ready_out}, 32'h1, "halt left");
    endtask : test_pci_overlay

    // Request held through further work, masked grant, then taken grant
    task automatic test_interrupt();
        int n;
        reset_dut(2, 16'h0040);
        prio_en <= 1'b0;
        run_op(OP_WR_TABLED, 1'b0, 4'h0, 1'b0, 32'h0, 1'b0);
        check(int_req_out, 1'b1, "request after store");
        run_op(OP_WR_TABLED, 1'b0, 4'h0, 1'b0, 32'h0, 1'b0);
        check(int_req_out, 1'b1, "request still pending");
        @(posedge clk_sys_in) begin
            mask_bit_in <= 1'b0;
            prio_en <= 1'b1;
        end
        repeat (6) @(negedge clk_sys_in);
        check(int_req_out, 1'b1, "masked grant ignored");
        @(posedge clk_sys_in) mask_bit_in <= 1'b1;
        n = 0;
        while (n < 4 && int_req_out !== 1'b0) begin
            @(negedge clk_sys_in);
            n++;
        end
        check(int_req_out, 1'b0, "request dropped on grant");
    endtask : test_interrupt

    // Idle mode: commands ignored, no storage use, no request
    task automatic test_idle();
        reset_dut(2, 16'h0008);
        @(posedge clk_sys_in) begin
            mode_in <= MODE_IDLE;
            cmd_in <= {1'b1, OP_WR_TABLED, 4'h0};
        end
        repeat (6) begin
            @(negedge clk_sys_in);
            check({mem_out.req, int_req_out}, 32'h0, "idle quiet");
        end
        @(posedge clk_sys_in) cmd_in.valid <= 1'b0;
    endtask : test_idle

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        rst_b_in = 1'b0;
        cmd_in = '0;
        mode_in = MODE_ACTIVE;
        count_in = 16'h0;
        mask_bit_in = 1'b1;
        prio_en = 1'b1;
        delay = 3'h0;
        flags = 2'b00;
        err_op = OP_RD_HARD;
        err_val = 4'h0;
        reset_dut(16, 16'h0008);
        test_codes();
        test_flags();
        test_pci_overlay();
        test_interrupt();
        test_idle();
        tally_and_finish();
    end
endmodule : sttr_subchannel_tb
`default_nettype wire
